/* File: include/ovl_defs.svh */
`ifndef OVL_DEFS_SVH
`define OVL_DEFS_SVH
// ----------------------------------------
// Content scale and settings
// ----------------------------------------
`define OVL_FULL_SCALE 16'h2710
`define OVL_START_CAP 16'h26AC
`define OVL_CLASS_MAX 6'h28
`define OVL_START_CLASS_DEF 6'h0A
`define OVL_HC_RATIO_MAX 7'h63
`define OVL_HC_RATIO_DEF 7'h3C
`define OVL_COOL_MIN 14'h000A
`define OVL_COOL_MAX 14'h270F
`define OVL_COOL_DEF 14'h012C
`define OVL_CLK_HZ 10000000
`define OVL_TICK_MS 100
`define OVL_TICK_CYC ((`OVL_CLK_HZ / 1000) * `OVL_TICK_MS)
`define OVL_DI1_DEF 4'h1
`define OVL_DI2_DEF 4'h5
`define OVL_DI3_DEF 4'h3
`endif

/* File: include/ovl_pkg.sv */
package ovl_pkg;
   // Operating modes reported by the motor control state machine
   typedef enum logic [2:0] {
      MODE_STOPPED = 3'b000,
      MODE_KICK = 3'b001,
      MODE_RAMP = 3'b010,
      MODE_RUN = 3'b011,
      MODE_STOPPING = 3'b100
   } motor_mode_t;
   // Digital input function selection
   typedef enum logic [3:0] {
      DI_OFF = 4'b0000,
      DI_STOP = 4'b0001,
      DI_FAULT_HIGH = 4'b0010,
      DI_FAULT_LOW = 4'b0011,
      DI_FAULT_RESET = 4'b0100,
      DI_BYPASS = 4'b0101,
      DI_EOL_RESET = 4'b0110,
      DI_LOCAL_REMOTE = 4'b0111,
      DI_HEAT_DIS = 4'b1000,
      DI_HEAT_EN = 4'b1001,
      DI_RAMP_SEL = 4'b1010
   } di_func_t;
endpackage : ovl_pkg

/* File: logic/input_mapper.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ovl_defs.svh"
module input_mapper
   import ovl_pkg::*;
(
   input wire logic [2:0] din_i,
   input wire logic [3:0] func0_i,
   input wire logic [3:0] func1_i,
   input wire logic [3:0] func2_i,
   output logic stop_o,
   output logic fault_o,
   output logic fault_reset_o,
   output logic bypass_o,
   output logic eol_reset_o,
   output logic remote_o,
   output logic heat_dis_o,
   output logic heat_en_o,
   output logic ramp2_o
);
   // ----------------------------------------
   // Per-function OR over the three inputs
   // ----------------------------------------
   function automatic logic hit(input logic [3:0] f, input logic [3:0] a,
                                input logic [3:0] b, input logic [3:0] c,
                                input logic [2:0] d);
      hit = (a == f && d[0]) || (b == f && d[1]) || (c == f && d[2]);
   endfunction : hit
   function automatic logic sel(input logic [3:0] f, input logic [3:0] a,
                                input logic [3:0] b, input logic [3:0] c);
      sel = (a == f) || (b == f) || (c == f);
   endfunction : sel
   // Off selections never match any function
   assign stop_o = hit(DI_STOP, func0_i, func1_i, func2_i, din_i);
   assign fault_o = hit(DI_FAULT_HIGH, func0_i, func1_i, func2_i, din_i)
      || hit(DI_FAULT_LOW, func0_i, func1_i, func2_i, ~din_i);
   assign fault_reset_o = hit(DI_FAULT_RESET, func0_i, func1_i, func2_i, din_i);
   assign bypass_o = hit(DI_BYPASS, func0_i, func1_i, func2_i, din_i);
   assign eol_reset_o = hit(DI_EOL_RESET, func0_i, func1_i, func2_i, din_i);
   assign remote_o = hit(DI_LOCAL_REMOTE, func0_i, func1_i, func2_i, din_i);
   assign heat_dis_o = hit(DI_HEAT_DIS, func0_i, func1_i, func2_i, din_i);
   // Heater enabled unless enable inputs exist and all of them are low
   assign heat_en_o = !sel(DI_HEAT_EN, func0_i, func1_i, func2_i)
      || hit(DI_HEAT_EN, func0_i, func1_i, func2_i, din_i);
   assign ramp2_o = hit(DI_RAMP_SEL, func0_i, func1_i, func2_i, din_i);
endmodule : input_mapper
`default_nettype wire

/* File: logic/motor_overload_and_input_mapper.sv */
// Overview of operation
// - Independent selection off: running class used in every state.
// - Independent on: starting class in kick and ramp, running class elsewhere.
// - Both classes off: content cleared, no overload calculation.
// - Independent on, start class off, run on: hold content in kick/ramp, cap 99%.
// - Starting class is off or 1 to 40, default 10.
// - Content kept as 0 to 100 percent, full scale means tripped.
// - Independent on, start class off: overload disabled while starting.
// - Hot/cold ratio 0 to 99 percent, default 60, sets steady state.
// - Steady state = ratio * current / full load / imbalance derate.
// - Content moves toward steady state at cooling time rate.
// - Cooling time up to 999.9 minutes, default 30.0, full to 1%.
// - Stopped motor: content decays exponentially from its value at stop.
// - Each input has its own function; off does nothing.
// - Stop function cancels 3-wire seal-in; default of input one.
// - Fault-high raises fault when input asserted.
// - Fault-low raises fault when input deasserted; default of input three.
// - Fault-reset input clears active fault when asserted.
// - Bypass confirm is contactor feedback; default of input two.
// - Emergency overload reset clears content after an overload trip.
// - Local/remote: low picks local, high picks remote source.
// - Heater disable input disables; heater enable input enables.
// - Ramp select enables second acceleration ramp while asserted.
`timescale 1ns/10ps
`default_nettype none
`include "ovl_defs.svh"
module motor_overload_and_input_mapper
   import ovl_pkg::*;
#(
   parameter int TICK_CYC = `OVL_TICK_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] mode_i,
   input wire logic indep_sr_i,
   input wire logic [5:0] start_class_i,
   input wire logic [5:0] run_class_i,
   input wire logic [6:0] hc_ratio_i,
   input wire logic [13:0] cool_time_i,
   input wire logic [15:0] current_i,
   input wire logic [15:0] full_load_current_i,
   input wire logic [15:0] service_factor_i,
   input wire logic [7:0] derate_i,
   input wire logic [2:0] din_i,
   input wire logic [3:0] di1_func_i,
   input wire logic [3:0] di2_func_i,
   input wire logic [3:0] di3_func_i,
   input wire logic cfg_load_i,
   input wire logic seal_set_i,
   output logic [15:0] thermal_overload_o,
   output logic [15:0] steady_state_overload_content_o,
   output logic overload_trip_o,
   output logic input_fault_o,
   output logic seal_in_o,
   output logic bypass_confirm_input_o,
   output logic remote_sel_o,
   output logic heater_on_o,
   output logic second_ramp_select_o,
   output logic [5:0] start_class_o,
   output logic [6:0] hc_ratio_o,
   output logic [13:0] cool_time_o
);
   // ----------------------------------------
   // Configuration registers with range check
   // ----------------------------------------
   logic [5:0] sclass_r;
   logic [6:0] ratio_r;
   logic [13:0] cool_r;
   logic [3:0] f1_r, f2_r, f3_r;
   wire sclass_ok = start_class_i <= `OVL_CLASS_MAX;
   wire ratio_ok = hc_ratio_i <= `OVL_HC_RATIO_MAX;
   wire cool_ok = cool_time_i >= `OVL_COOL_MIN && cool_time_i <= `OVL_COOL_MAX;
   // Load settings; out-of-range class, ratio or cooling values keep the old setting
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclass_r <= `OVL_START_CLASS_DEF;
         ratio_r <= `OVL_HC_RATIO_DEF;
         cool_r <= `OVL_COOL_DEF;
         f1_r <= `OVL_DI1_DEF;
         f2_r <= `OVL_DI2_DEF;
         f3_r <= `OVL_DI3_DEF;
      end else if (cfg_load_i) begin
         if (sclass_ok) sclass_r <= start_class_i;
         if (ratio_ok) ratio_r <= hc_ratio_i;
         if (cool_ok) cool_r <= cool_time_i;
         f1_r <= di1_func_i;
         f2_r <= di2_func_i;
         f3_r <= di3_func_i;
      end
   end

   // ----------------------------------------
   // Input function decode
   // ----------------------------------------
   logic m_stop, m_fault, m_freset, m_bypass, m_eol, m_remote, m_heater_disable_input, m_hen, m_ramp2;
   input_mapper u_map (
      .din_i(din_i),
      .func0_i(f1_r),
      .func1_i(f2_r),
      .func2_i(f3_r),
      .stop_o(m_stop),
      .fault_o(m_fault),
      .fault_reset_o(m_freset),
      .bypass_o(m_bypass),
      .eol_reset_o(m_eol),
      .remote_o(m_remote),
      .heat_dis_o(m_heater_disable_input),
      .heat_en_o(m_hen),
      .ramp2_o(m_ramp2)
   );

   // ----------------------------------------
   // Class selection per operating state
   // ----------------------------------------
   wire starting = (mode_i == MODE_KICK) || (mode_i == MODE_RAMP);
   wire stopped = (mode_i == MODE_STOPPED);
   wire [5:0] act_class = (indep_sr_i && starting) ? sclass_r : run_class_i;
   wire both_off = (sclass_r == 6'h00) && (run_class_i == 6'h00);
   wire start_hold = indep_sr_i && starting && (sclass_r == 6'h00);

   // ----------------------------------------
   // Steady-state content (hundredths of percent)
   // ----------------------------------------
   function automatic logic [15:0] sat16(input logic [39:0] v);
      sat16 = (v > 40'h00_0000_2710) ? `OVL_FULL_SCALE : v[15:0];
   endfunction : sat16
   wire [15:0] full_load_current = (full_load_current_i == 16'h0000) ? 16'h0001 : full_load_current_i;
   wire [7:0] der = (derate_i == 8'h00) ? 8'h64 : derate_i;
   // ratio% * I/FULL_LOAD_CURRENT * 100/derate% in hundredths of percent
   wire [39:0] ss_num = 40'(ratio_r) * 40'(current_i) * 40'h00_0000_2710;
   wire [39:0] ss_den = 40'(full_load_current) * 40'(der);
   wire [15:0] ss_val = sat16(ss_num / ss_den);
   // Above full load times service factor the content target is full scale, except when stopped
   wire [31:0] sf_lim = 32'(full_load_current) * 32'(service_factor_i) / 32'h0000_0064;
   wire over_sf = 32'(current_i) > sf_lim;

   // ----------------------------------------
   // Time base and exponential step
   // ----------------------------------------
   logic [31:0] tick_cnt_r;
   wire tick = tick_cnt_r == 32'(TICK_CYC - 1);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) tick_cnt_r <= 32'h0000_0000;
      else tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
   end
   // Time constant = cool/ln(100); cool in 0.1 min, ticks of 0.1 s: tau = cool*60/4.6
   wire [23:0] tau_ticks = 24'(cool_r) * 24'h00_000D;
   function automatic logic [15:0] approach(input logic [15:0] cur,
                                            input logic [15:0] tgt,
                                            input logic [23:0] tau);
      logic [39:0] d;
      logic [39:0] s;
      d = (cur > tgt) ? 40'(cur - tgt) : 40'(tgt - cur);
      // Step rounded up, so content closes the last few counts to target while tau is at most 65536 ticks
      s = ((d << 16) / 40'(tau) + 40'h00_0000_FFFF) >> 16;
      if (cur > tgt) approach = cur - 16'(s);
      else approach = cur + 16'(s);
   endfunction : approach

   // ----------------------------------------
   // Overload content and trip
   // ----------------------------------------
   logic [15:0] ol_r, ol_nxt;
   logic trip_r;
   logic [15:0] target;
   // Content next value
   always_comb begin
      target = stopped ? 16'h0000 : (over_sf ? `OVL_FULL_SCALE : ss_val);
      ol_nxt = ol_r;
      if (both_off) ol_nxt = 16'h0000;
      else if (m_eol && trip_r) ol_nxt = 16'h0000;
      else if (start_hold) ol_nxt = (ol_r > `OVL_START_CAP) ? `OVL_START_CAP : ol_r;
      else if (act_class == 6'h00) ol_nxt = ol_r;
      else if (tick) ol_nxt = approach(ol_r, target, tau_ticks);
      if (ol_nxt > `OVL_FULL_SCALE) ol_nxt = `OVL_FULL_SCALE;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) ol_r <= 16'h0000;
      else ol_r <= ol_nxt;
   end
   // Trip sets at full scale; set wins over reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) trip_r <= 1'b0;
      else if (ol_nxt == `OVL_FULL_SCALE && !both_off) trip_r <= 1'b1;
      else if (m_freset) trip_r <= 1'b0;
   end

   // ----------------------------------------
   // Seal-in and registered outputs
   // ----------------------------------------
   logic seal_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) seal_r <= 1'b0;
      else if (m_stop) seal_r <= 1'b0;
      else if (seal_set_i) seal_r <= 1'b1;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         thermal_overload_o <= 16'h0000;
         steady_state_overload_content_o <= 16'h0000;
         overload_trip_o <= 1'b0;
         input_fault_o <= 1'b0;
         bypass_confirm_input_o <= 1'b0;
         remote_sel_o <= 1'b0;
         heater_on_o <= 1'b0;
         second_ramp_select_o <= 1'b0;
      end else begin
         thermal_overload_o <= ol_r;
         steady_state_overload_content_o <= ss_val;
         overload_trip_o <= trip_r;
         input_fault_o <= m_fault;
         bypass_confirm_input_o <= m_bypass;
         remote_sel_o <= m_remote;
         heater_on_o <= m_hen && !m_heater_disable_input;
         second_ramp_select_o <= m_ramp2;
      end
   end
   assign seal_in_o = seal_r;
   assign start_class_o = sclass_r;
   assign hc_ratio_o = ratio_r;
   assign cool_time_o = cool_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_trip_reset;
      m_freset && !(ol_nxt == `OVL_FULL_SCALE);
   endsequence
   AST_BOTH_OFF_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      both_off |=> ol_r == 16'h0000) else $error("content not cleared");
   AST_START_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
      start_hold && !both_off && !(m_eol && trip_r) |=> ol_r <= `OVL_START_CAP)
      else $error("start cap exceeded");
   AST_START_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      start_hold && !both_off && !(m_eol && trip_r) |=> ol_r <= $past(ol_r))
      else $error("content grew while starting disabled");
   AST_FULL_SCALE: assert property (@(posedge clk_i) disable iff (rst_i)
      ol_r <= `OVL_FULL_SCALE) else $error("content above full scale");
   AST_TRIP_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      ol_r == `OVL_FULL_SCALE && !both_off |-> ##[0:1] trip_r) else $error("no trip");
   AST_TRIP_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      trip_r ##0 s_trip_reset |=> !trip_r ##1 overload_trip_o == 1'b0)
      else $error("trip not reset");
   AST_EOL: assert property (@(posedge clk_i) disable iff (rst_i)
      m_eol && trip_r && !both_off |=> ol_r == 16'h0000 ##1 thermal_overload_o == 16'h0000)
      else $error("emergency reset failed");
   AST_SEAL: assert property (@(posedge clk_i) disable iff (rst_i)
      m_stop |=> !seal_in_o) else $error("stop did not drop seal");
   AST_COOL_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      cool_r <= `OVL_COOL_MAX) else $error("cooling time out of range");
   AST_CLASS_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      sclass_r <= `OVL_CLASS_MAX) else $error("start class out of range");
endmodule : motor_overload_and_input_mapper
`default_nettype wire

/* File: tb/starter_model.sv */
`timescale 1ns/10ps
`default_nettype none
module starter_model (
   input wire logic clk_i,
   input wire logic [2:0] mode_req_i,
   input wire logic [2:0] din_req_i,
   input wire logic seal_req_i,
   output var logic [2:0] mode_o,
   output var logic [2:0] din_o,
   output var logic seal_set_o
);
   // Known levels before the first edge
   initial begin
      mode_o = 3'h0;
      din_o = 3'h0;
      seal_set_o = 1'b0;
   end
   // State machine mode, field input levels and seal-in pulse, one edge behind
   always @(posedge clk_i) begin
      mode_o <= mode_req_i;
      din_o <= din_req_i;
      seal_set_o <= seal_req_i;
   end
endmodule : starter_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ovl_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench
   import ovl_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, indep = 1'b0, cfg_load = 1'b0, seal_req = 1'b0;
   logic [2:0] mode_req = 3'h0, din_req = 3'h0, mode, din;
   logic seal_set, trip, ifault, seal, bypass_confirm_input, remote, heat, ramp2;
   logic [5:0] sclass = 6'h0A, rclass = 6'h0A, sclass_o;
   logic [6:0] hc = 7'h3C, hc_o;
   logic [13:0] cool = 14'h000A, cool_o;
   logic [15:0] cur = 16'h0064, full_load_current = 16'h0064, sf = 16'h0073, tol, ss;
   logic [7:0] der = 8'h64;
   logic [3:0] f1 = 4'h1, f2 = 4'h5, f3 = 4'h3;
   int bad_count = 0, cmp_count = 0, cyc = 0, i;
   // Input mapper table: function, level, expected {remote, ramp2, heater, fault}
   logic [3:0] tf [10] = '{DI_OFF, DI_FAULT_HIGH, DI_FAULT_HIGH, DI_FAULT_LOW, DI_LOCAL_REMOTE,
      DI_LOCAL_REMOTE, DI_HEAT_DIS, DI_HEAT_EN, DI_HEAT_EN, DI_RAMP_SEL};
   logic td [10] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [3:0] te [10] = '{4'h2, 4'h3, 4'h2, 4'h3, 4'h2, 4'hA, 4'h0, 4'h0, 4'h2, 4'h6};

   always #50 clk_i = ~clk_i;

   starter_model u_model (.clk_i(clk_i), .mode_req_i(mode_req), .din_req_i(din_req),
      .seal_req_i(seal_req), .mode_o(mode), .din_o(din), .seal_set_o(seal_set));

   motor_overload_and_input_mapper #(.TICK_CYC(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .mode_i(mode), .indep_sr_i(indep), .start_class_i(sclass), .run_class_i(rclass),
      .hc_ratio_i(hc), .cool_time_i(cool), .current_i(cur), .full_load_current_i(full_load_current),
      .service_factor_i(sf), .derate_i(der), .din_i(din), .di1_func_i(f1), .di2_func_i(f2),
      .di3_func_i(f3), .cfg_load_i(cfg_load), .seal_set_i(seal_set),
      .thermal_overload_o(tol), .steady_state_overload_content_o(ss),
      .overload_trip_o(trip), .input_fault_o(ifault), .seal_in_o(seal),
      .bypass_confirm_input_o(bypass_confirm_input), .remote_sel_o(remote), .heater_on_o(heat),
      .second_ramp_select_o(ramp2), .start_class_o(sclass_o), .hc_ratio_o(hc_o),
      .cool_time_o(cool_o));

   // ----------------------------------------
   // Bench tasks
   // ----------------------------------------
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   task automatic load_cfg(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
      @(posedge clk_i);
      f1 <= a;
      f2 <= b;
      f3 <= c;
      cfg_load <= 1'b1;
      @(posedge clk_i);
      cfg_load <= 1'b0;
      tick(2);
   endtask : load_cfg

   task automatic set_din(input logic [2:0] v);
      @(posedge clk_i);
      din_req <= v;
      tick(3);
   endtask : set_din

   task automatic seal_pulse();
      @(posedge clk_i);
      seal_req <= 1'b1;
      @(posedge clk_i);
      seal_req <= 1'b0;
      tick(3);
   endtask : seal_pulse

   // Run a mode for a while and see whether content rose, fell or held
   task automatic acc(input logic [2:0] m, input logic ind, input int dir);
      logic [15:0] c0;
      @(posedge clk_i);
      mode_req <= m;
      indep <= ind;
      tick(20);
      c0 = tol;
      tick(300);
      if (dir > 0) `CHK(tol > c0, 1'b1)
      else if (dir < 0) `CHK(tol < c0, 1'b1)
      else `CHK(tol, c0)
   endtask : acc

   // Cut a hung run short
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         close_out();
      end
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(1);
      `CHK(sclass_o, `OVL_START_CLASS_DEF)
      `CHK(hc_o, `OVL_HC_RATIO_DEF)
      `CHK(cool_o, `OVL_COOL_DEF)
      `CHK(tol, 16'h0000)
      seal_pulse();
      `CHK(seal, 1'b1)
      set_din(3'b001);
      `CHK(seal, 1'b0)
      `CHK(ifault, 1'b1)
      set_din(3'b110);
      `CHK(bypass_confirm_input, 1'b1)
      `CHK(ifault, 1'b0)
      $display("defaults and seal-in done");
      @(posedge clk_i);
      sclass <= 6'h00;
      load_cfg(DI_OFF, DI_OFF, DI_OFF);
      set_din(3'b000);
      seal_pulse();
      set_din(3'b001);
      `CHK(seal, 1'b1)
      `CHK(bypass_confirm_input, 1'b0)
      for (i = 0; i < 10; i++) begin
         load_cfg(tf[i], DI_OFF, DI_OFF);
         set_din({2'b00, td[i]});
         `CHK({remote, ramp2, heat, ifault}, te[i])
      end
      $display("input mapper done");
      set_din(3'b000);
      @(posedge clk_i);
      mode_req <= MODE_RUN;
      tick(5);
      `CHK(ss, 16'h1770)
      @(posedge clk_i);
      cur <= 16'h00C8;
      acc(MODE_KICK, 1'b0, 1'b1);
      acc(MODE_KICK, 1'b1, 1'b0);
      @(posedge clk_i);
      sclass <= 6'h0A;
      rclass <= 6'h00;
      load_cfg(DI_OFF, DI_OFF, DI_OFF);
      acc(MODE_RAMP, 1'b0, 1'b0);
      acc(MODE_RAMP, 1'b1, 1'b1);
      $display("class selection done");
      @(posedge clk_i);
      rclass <= 6'h0A;
      mode_req <= MODE_RUN;
      for (i = 0; i < 20000 && trip !== 1'b1; i++) tick(1);
      `CHK(trip, 1'b1)
      `CHK(tol, `OVL_FULL_SCALE)
      acc(MODE_STOPPED, 1'b1, -1);
      @(posedge clk_i);
      cur <= 16'h0000;
      tick(20);
      i = tol;
      tick(300);
      `CHK(tol < i[15:0], 1'b1)
      `CHK(trip, 1'b1)
      load_cfg(DI_EOL_RESET, DI_OFF, DI_OFF);
      set_din(3'b001);
      `CHK(tol, 16'h0000)
      set_din(3'b000);
      load_cfg(DI_FAULT_RESET, DI_OFF, DI_OFF);
      set_din(3'b001);
      `CHK(trip, 1'b0)
      set_din(3'b000);
      $display("trip and resets done");
      @(posedge clk_i);
      cur <= 16'h00C8;
      acc(MODE_RUN, 1'b1, 1'b1);
      @(posedge clk_i);
      rclass <= 6'h00;
      sclass <= 6'h00;
      load_cfg(DI_OFF, DI_OFF, DI_OFF);
      `CHK(tol, 16'h0000)
      @(posedge clk_i);
      sclass <= 6'h29;
      hc <= 7'h64;
      load_cfg(DI_OFF, DI_OFF, DI_OFF);
      `CHK(sclass_o, 6'h00)
      `CHK(hc_o, `OVL_HC_RATIO_DEF)
      $display("classes off done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
